/* pfs_mem_model.sv */
// data memory path model: turns the unit's addresses into bank numbers
// assumes 128-byte banks, four of them
`timescale 1ns/1ps
`default_nettype none
module pfs_mem_model (
  input wire logic [8:0] dir_addr,
  input wire logic [8:0] ind_addr,
  output logic [1:0] dir_bank,
  output logic [1:0] ind_bank
);
  assign dir_bank = dir_addr[8:7];
  assign ind_bank = ind_addr[8:7];
endmodule // pfs_mem_model
`default_nettype wire

/* pfs_pkg.sv */
// package for the program flow and status unit
// assumes a single core clock and an apb master for register access
package pfs_pkg;
  // ****************************************
  // register map (byte addresses on apb)
  // ****************************************
  localparam logic [7:0] STATUS_IDX = 8'h03;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_PCLOW = 12'h008;
  localparam logic [11:0] ADDR_PC_HIGH_LATCH = 12'h028;
  localparam logic [11:0] ADDR_FLOW = 12'h040;
  localparam logic [11:0] ADDR_ALU = 12'h044;
  localparam logic [11:0] ADDR_ALURES = 12'h048;
  localparam logic [11:0] ADDR_PCFULL = 12'h04c;
  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_WDOG = 4;
  localparam int ST_BANK_LO = 5;
  localparam int ST_BANK_HI = 6;
  localparam int ST_IND = 7;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] STATUS_WMASK = 8'he7;
  localparam logic [7:0] STATUS_FLAGS = 8'h07;
  localparam logic [7:0] STATUS_CLRMASK = 8'h1f;
  localparam logic [7:0] STATUS_CLRSET = 8'h04;
  // ****************************************
  // program counter and stack
  // ****************************************
  localparam int PC_W = 13;
  localparam int TGT_W = 11;
  localparam int STK_DEPTH = 8;
  localparam int STK_AW = 3;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [7:0] LATCH_RST = 8'h00;
  // ****************************************
  // flow command codes (flow register bits 15:13)
  // ****************************************
  typedef enum logic [2:0]
  {
    FLOW_STEP = 3'h0,
    FLOW_JUMP = 3'h1,
    FLOW_CALL = 3'h2,
    FLOW_RET = 3'h3,
    FLOW_INTR = 3'h4
  } pfs_flow_e;
  // alu op codes (alu register bits 19:16)
  typedef enum logic [3:0]
  {
    ALU_ADD = 4'h0,
    ALU_SUB = 4'h1,
    ALU_AND = 4'h2,
    ALU_OR = 4'h3,
    ALU_XOR = 4'h4,
    ALU_CLR = 4'h5,
    ALU_MOV = 4'h6
  } pfs_alu_e;
endpackage

/* pfs_stack_mem.sv */
// return stack storage: eight words of thirteen bits
// assumes the caller keeps the pointer; read data is registered
`timescale 1ns/1ps
`default_nettype none
module pfs_stack_mem (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [pfs_pkg::STK_AW-1:0] wr_addr,
  input wire logic [pfs_pkg::PC_W-1:0] wr_data,
  input wire logic [pfs_pkg::STK_AW-1:0] rd_addr,
  output logic [pfs_pkg::PC_W-1:0] rd_data
);
  logic [pfs_pkg::PC_W-1:0] mem [pfs_pkg::STK_DEPTH];

  always_ff @(posedge clk)
  begin
    if (ce && wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // pfs_stack_mem
`default_nettype wire

/* pfs_unit.sv */
// program flow and status unit: status register, program counter, paging and return stack
// assumes an apb master stands in for the instruction decoder; all on one clock
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pfs_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] dir_offset,
  input wire logic [7:0] ind_pointer,
  output logic [8:0] dir_addr,
  output logic [8:0] ind_addr,
  output logic [12:0] pc_out
);
  // ****************************************
  // bus decode
  // ****************************************
  logic acc;
  logic wr;
  logic hit_status;
  logic hit_pclow;
  logic hit_latch;
  logic hit_flow;
  logic hit_alu;
  logic hit_res;
  logic hit_pcf;
  logic mapped;

  assign acc = psel && penable && ce;
  assign wr = acc && pwrite;
  assign hit_status = paddr == pfs_pkg::ADDR_STATUS;
  assign hit_pclow = paddr == pfs_pkg::ADDR_PCLOW;
  assign hit_latch = paddr == pfs_pkg::ADDR_PC_HIGH_LATCH;
  assign hit_flow = paddr == pfs_pkg::ADDR_FLOW;
  assign hit_alu = paddr == pfs_pkg::ADDR_ALU;
  assign hit_res = paddr == pfs_pkg::ADDR_ALURES;
  assign hit_pcf = paddr == pfs_pkg::ADDR_PCFULL;
  assign mapped = hit_status || hit_pclow || hit_latch || hit_flow || hit_alu || hit_res || hit_pcf;
  // zero wait states, so the handshake output can be combinational
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ****************************************
  // alu: result and flags
  // ****************************************
  logic [7:0] status_reg;
  logic [7:0] alu_res_reg;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [3:0] op;
  logic to_status;
  logic alu_go;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic aff_z;
  logic aff_cdc;

  assign opa = pwdata[7:0];
  assign opb = pwdata[15:8];
  assign op = pwdata[19:16];
  assign to_status = pwdata[20];
  assign alu_go = wr && hit_alu && pstrb[2];

  always_comb
  begin
    sum = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    aff_z = 1'b1;
    aff_cdc = 1'b0;
    unique case (pfs_pkg::pfs_alu_e'(op))
      pfs_pkg::ALU_ADD:
      begin
        sum = {1'b0, opa} + {1'b0, opb};
        nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
        res = sum[7:0];
        aff_cdc = 1'b1;
      end
      pfs_pkg::ALU_SUB:
      begin
        // a - b as a + ~b + 1, so c and dc come out as inverted borrows
        sum = {1'b0, opa} + {1'b0, ~opb} + 9'h001;
        nib = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01;
        res = sum[7:0];
        aff_cdc = 1'b1;
      end
      pfs_pkg::ALU_AND: res = opa & opb;
      pfs_pkg::ALU_OR: res = opa | opb;
      pfs_pkg::ALU_XOR: res = opa ^ opb;
      pfs_pkg::ALU_CLR: res = 8'h00;
      pfs_pkg::ALU_MOV:
      begin
        res = opa;
        aff_z = 1'b0;
      end
      default:
      begin
        res = opa;
        aff_z = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      alu_res_reg <= 8'h00;
    end
    else if (ce && alu_go)
    begin
      alu_res_reg <= res;
    end
  end

  // ****************************************
  // status register
  // ****************************************
  logic [7:0] flag_upd;
  logic [7:0] flag_mask;
  logic [7:0] status_next;

  always_comb
  begin
    flag_upd = 8'h00;
    flag_mask = 8'h00;
    flag_upd[pfs_pkg::ST_ZERO] = res == 8'h00;
    flag_upd[pfs_pkg::ST_CARRY] = sum[8];
    flag_upd[pfs_pkg::ST_DIGIT] = nib[4];
    flag_mask[pfs_pkg::ST_ZERO] = aff_z;
    flag_mask[pfs_pkg::ST_CARRY] = aff_cdc;
    flag_mask[pfs_pkg::ST_DIGIT] = aff_cdc;
    status_next = status_reg;
    if (wr && hit_status)
    begin
      // direct software write: only the writable bits take the data
      status_next = (status_reg & ~pfs_pkg::STATUS_WMASK) | (pwdata[7:0] & pfs_pkg::STATUS_WMASK);
    end
    else if (alu_go)
    begin
      if (to_status && pfs_pkg::pfs_alu_e'(op) == pfs_pkg::ALU_CLR)
      begin
        status_next = (status_reg & pfs_pkg::STATUS_CLRMASK & ~pfs_pkg::STATUS_FLAGS) | pfs_pkg::STATUS_CLRSET;
        status_next = status_next | (status_reg & pfs_pkg::STATUS_FLAGS & ~flag_mask & ~pfs_pkg::STATUS_CLRSET);
      end
      else if (to_status)
      begin
        // result lands on the writable bits except any flag the op itself produced
        status_next = (status_reg & ~(pfs_pkg::STATUS_WMASK & ~flag_mask))
          | (res & pfs_pkg::STATUS_WMASK & ~flag_mask);
        status_next = (status_next & ~flag_mask) | (flag_upd & flag_mask);
      end
      else
      begin
        status_next = (status_reg & ~flag_mask) | (flag_upd & flag_mask);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_reg <= pfs_pkg::STATUS_RST;
    end
    else if (ce)
    begin
      status_reg <= status_next;
    end
  end

  // bank addressing
  assign dir_addr = {status_reg[pfs_pkg::ST_BANK_HI:pfs_pkg::ST_BANK_LO], dir_offset};
  assign ind_addr = {status_reg[pfs_pkg::ST_IND], ind_pointer};

  // ****************************************
  // program counter and high latch
  // ****************************************
  logic [12:0] pc_reg;
  logic [7:0] latch_reg;
  logic [2:0] flow_cmd;
  logic flow_go;
  logic [10:0] target;
  logic [2:0] sp_reg;
  logic [2:0] sp_prev;
  logic push;
  logic pop;
  logic [12:0] stk_rd;
  logic ret_pend_reg;

  assign flow_go = wr && hit_flow;
  assign flow_cmd = pwdata[15:13];
  assign target = pwdata[10:0];
  assign push = flow_go && (flow_cmd == pfs_pkg::FLOW_CALL || flow_cmd == pfs_pkg::FLOW_INTR);
  assign pop = flow_go && flow_cmd == pfs_pkg::FLOW_RET;
  assign sp_prev = sp_reg - 3'h1;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      latch_reg <= pfs_pkg::LATCH_RST;
    else if (ce && wr && hit_latch)
      latch_reg <= pwdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pc_reg <= pfs_pkg::PC_RST;
    end
    else if (ce)
    begin
      if (ret_pend_reg)
      begin
        pc_reg <= stk_rd;
      end
      else if (wr && hit_pclow)
      begin
        pc_reg <= {latch_reg[4:0], pwdata[7:0]};
      end
      else if (flow_go)
      begin
        unique case (pfs_pkg::pfs_flow_e'(flow_cmd))
          pfs_pkg::FLOW_STEP: pc_reg <= pc_reg + 13'h0001;
          pfs_pkg::FLOW_JUMP, pfs_pkg::FLOW_CALL: pc_reg <= {latch_reg[4:3], target};
          pfs_pkg::FLOW_INTR: pc_reg <= pfs_pkg::INT_VECTOR;
          default: pc_reg <= pc_reg;
        endcase
      end
    end
  end

  // ****************************************
  // return stack
  // ****************************************
  // pointer wraps freely; no overflow flag by design
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sp_reg <= 3'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        sp_reg <= sp_reg + 3'h1;
      end
      else if (pop)
      begin
        sp_reg <= sp_prev;
      end
    end
  end

  // the memory read is registered, so the pop finishes one cycle later
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ret_pend_reg <= 1'b0;
    else if (ce)
      ret_pend_reg <= pop;
  end

  pfs_stack_mem u_stack (
    .clk(clk),
    .ce(ce),
    .wr_en(push),
    .wr_addr(sp_reg),
    .wr_data(flow_cmd == pfs_pkg::FLOW_INTR ? pc_reg : pc_reg + 13'h0001),
    .rd_addr(sp_prev),
    .rd_data(stk_rd)
  );

  assign pc_out = pc_reg;

  // ****************************************
  // read mux
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h00000000;
    end
    else if (ce && psel && !penable && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (hit_status)
        prdata <= {24'h000000, status_reg};
      else if (hit_pclow)
        prdata <= {24'h000000, pc_reg[7:0]};
      else if (hit_latch)
        prdata <= {24'h000000, latch_reg};
      else if (hit_res)
        prdata <= {24'h000000, alu_res_reg};
      else if (hit_pcf)
        prdata <= {19'h00000, pc_reg};
    end
  end
endmodule // pfs_unit
`default_nettype wire

/* pfs_unit_sva.sv */
// concurrent checks on the ports of the program flow and status unit
// assumes one core clock, synchronous active-high reset, zero-wait apb
`timescale 1ns/1ps
`default_nettype none
module pfs_unit_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] dir_offset,
  input wire logic [7:0] ind_pointer,
  input wire logic [8:0] dir_addr,
  input wire logic [8:0] ind_addr,
  input wire logic [12:0] pc_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && ce && paddr == a;
  endsequence
  sequence s_flow(logic [2:0] c);
    s_wr(pfs_pkg::ADDR_FLOW) ##0 pwdata[15:13] == c;
  endsequence
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access phase without pready");
  AST_SLVERR: assert property (pslverr |-> psel && penable && paddr != pfs_pkg::ADDR_STATUS)
    else $error("error response outside access or on status");
  AST_DIR: assert property (dir_addr[6:0] == dir_offset)
    else $error("direct offset not passed through");
  AST_IND: assert property (ind_addr[7:0] == ind_pointer)
    else $error("indirect pointer not passed through");
  AST_BANK: assert property (s_wr(pfs_pkg::ADDR_STATUS) |=> dir_addr[8:7] == $past(pwdata[6:5])
    && ind_addr[8] == $past(pwdata[7]))
    else $error("bank bits do not follow status write");
  AST_PC_RESET: assert property ($fell(sys_rst) && $past(ce) |-> pc_out == 13'h0000)
    else $error("pc not cleared by reset");
  AST_PCL_LOAD: assert property (s_wr(pfs_pkg::ADDR_PCLOW) |=> pc_out[7:0] == $past(pwdata[7:0]))
    else $error("pc low byte not loaded");
  AST_JUMP: assert property (s_flow(3'h1) |=> pc_out[10:0] == $past(pwdata[10:0]))
    else $error("jump target not taken");
  AST_INTR: assert property (s_flow(3'h4) |=> pc_out == pfs_pkg::INT_VECTOR)
    else $error("interrupt vector not taken");
  AST_STEP: assert property (s_flow(3'h0) |=> pc_out == $past(pc_out) + 13'h0001)
    else $error("step did not advance pc");
endmodule // pfs_unit_sva
bind pfs_unit pfs_unit_sva i_sva (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .dir_offset(dir_offset), .ind_pointer(ind_pointer), .dir_addr(dir_addr), .ind_addr(ind_addr),
  .pc_out(pc_out));
`default_nettype wire

/* program_flow_status_unit_tb.sv */
// self-checking bench for the program flow and status unit
// assumes the apb master here stands in for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module program_flow_status_unit_tb;
  logic clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [6:0] dir_offset;
  logic [7:0] ind_pointer;
  logic [8:0] dir_addr, ind_addr;
  logic [12:0] pc_out;
  logic [1:0] dir_bank, ind_bank;
  logic e;
  int err_total = 0;
  int checks_done = 0;
  pfs_unit i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dir_offset(dir_offset), .ind_pointer(ind_pointer),
    .dir_addr(dir_addr), .ind_addr(ind_addr), .pc_out(pc_out));
  pfs_mem_model i_mem (.dir_addr(dir_addr), .ind_addr(ind_addr), .dir_bank(dir_bank),
    .ind_bank(ind_bank));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic fl(input logic [2:0] c, input logic [10:0] t);
    wr(pfs_pkg::ADDR_FLOW, {16'h0, c, 2'h0, t});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_status();
    rd(pfs_pkg::ADDR_STATUS, 32'h18);
    wr(pfs_pkg::ADDR_STATUS, 32'h0);
    rd(pfs_pkg::ADDR_STATUS, 32'h18);
    for (int i = 0; i < 8; i++)
    begin
      wr(pfs_pkg::ADDR_STATUS, 32'(i) << 5);
      @(posedge clk);
      chk(32'(dir_bank), 32'(i & 3));
      chk(32'(ind_bank), {30'h0, i[2], 1'b1});
    end
  endtask
  task automatic t_alu();
    wr(pfs_pkg::ADDR_STATUS, 32'h0);
    wr(pfs_pkg::ADDR_ALU, {11'h0, 1'b1, pfs_pkg::ALU_ADD, 8'h21, 8'h8f});
    rd(pfs_pkg::ADDR_STATUS, 32'hba);
    rd(pfs_pkg::ADDR_ALURES, 32'hb0);
    wr(pfs_pkg::ADDR_ALU, {11'h0, 1'b0, pfs_pkg::ALU_SUB, 8'h01, 8'h10});
    rd(pfs_pkg::ADDR_STATUS, 32'hb9);
    rd(pfs_pkg::ADDR_ALURES, 32'h0f);
    wr(pfs_pkg::ADDR_ALU, {11'h0, 1'b1, pfs_pkg::ALU_CLR, 16'h0});
    rd(pfs_pkg::ADDR_STATUS, 32'h1d);
    wr(pfs_pkg::ADDR_ALU, {11'h0, 1'b1, pfs_pkg::ALU_MOV, 8'h00, 8'he5});
    rd(pfs_pkg::ADDR_STATUS, 32'hfd);
    rd(pfs_pkg::ADDR_ALURES, 32'he5);
    wr(pfs_pkg::ADDR_ALU, {11'h0, 1'b0, pfs_pkg::ALU_XOR, 8'h0f, 8'h3c});
    rd(pfs_pkg::ADDR_STATUS, 32'hf9);
    rd(pfs_pkg::ADDR_ALURES, 32'h33);
  endtask
  task automatic t_pc();
    wr(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h1f);
    wr(pfs_pkg::ADDR_PCLOW, 32'h34);
    rd(pfs_pkg::ADDR_PCFULL, 32'h1f34);
    rd(pfs_pkg::ADDR_PCLOW, 32'h34);
    fl(3'h1, 11'h123);
    rd(pfs_pkg::ADDR_PCFULL, 32'h1923);
    wr(pfs_pkg::ADDR_PCLOW, 32'h05);
    rd(pfs_pkg::ADDR_PCFULL, 32'h1f05);
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h00);
    ce <= 1'b1;
    rd(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h1f);
    apb(1'b1, 12'hffc, 32'h5a);
    chk({31'h0, e}, 32'h1);
    rd(12'hffc, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_stack();
    wr(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h0);
    wr(pfs_pkg::ADDR_PCLOW, 32'h0);
    wr(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h08);
    // nine calls: the last one lands on the oldest slot
    for (int k = 0; k < 9; k++)
      fl(3'h2, 11'(k * 16));
    for (int j = 8; j > 0; j--)
    begin
      fl(3'h3, 11'h0);
      rd(pfs_pkg::ADDR_PCFULL, 32'h801 + 32'((j - 1) * 16));
    end
    fl(3'h3, 11'h0);
    rd(pfs_pkg::ADDR_PCFULL, 32'h871);
    rd(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h08);
    fl(3'h4, 11'h0);
    rd(pfs_pkg::ADDR_PCFULL, 32'h004);
    fl(3'h0, 11'h0);
    // page bits now differ from the stacked page, so a latch-based return would show
    wr(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h10);
    fl(3'h3, 11'h0);
    rd(pfs_pkg::ADDR_PCFULL, 32'h871);
  endtask
  task automatic t_reset();
    wr(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h1f);
    wr(pfs_pkg::ADDR_PCLOW, 32'h55);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(pfs_pkg::ADDR_PCFULL, 32'h0);
    rd(pfs_pkg::ADDR_PC_HIGH_LATCH, 32'h0);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    dir_offset = 7'h55;
    ind_pointer = 8'h80;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_status();
    t_alu();
    t_pc();
    t_stack();
    t_reset();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule // program_flow_status_unit_tb
`default_nettype wire
